// File: logic/sbrc_pkg.sv
// standby and reset control package: constants, states and the rule summary
// What this block does
// - writing 1 to bit 7 of system_control_one requests oscillator-off standby
// - level mode: standby request with wake pin high skips straight to warm-up
// - leaving standby clears the standby request bit automatically
// - once warm-up starts, standby is never re-entered even if pin falls
// - edge-to-level switch during standby still needs a rising edge to leave
// - edge mode: rising edge on wake pin releases standby
// - edge mode: standby is entered even while wake pin is high
// - release restarts only the oscillator; core held idle during warm-up
// - warmup_select codes 00, 01, 10 valid; 11 reserved
// - warm-up 3x2^16, 2^16, 2^14 clocks; divider select 1 doubles each (divider select is fixed to 0 in this part, so no doubling)
// - after warm-up resume next instruction; prescaler and divider start at zero
// - reset pin low in any standby resets the device into normal mode
// - idle mode halts cpu and watchdog, peripherals keep running
// - idle keeps memory and latches; pc held two instructions ahead
// - master enable 0: enabled source wakes idle without vectoring
// - master enable 1: enabled source wakes idle into its handler
// - watchdog interrupt pending before idle request: service it, skip idle
// - seven reset sources are combined into one device reset
// - internal reset sources are not themselves cleared at power-on
// - power-on and trimming resets hold reset until power-on warm-up ends
// - reset clears bank select, master enable, latches, nesting, prescaler; sets jump flag
// - reset pin release starts fetch from the reset vector
package sbrc_pkg;
   // register map of the plain register port
   localparam logic [3:0] ADDR_SYSCTL1 = 4'h0;
   localparam logic [3:0] ADDR_SYSCTL2 = 4'h1;
   localparam logic [3:0] ADDR_IRQ_EN = 4'h2;
   localparam logic [3:0] ADDR_IRQ_LATCH = 4'h3;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   // system_control_one fields
   localparam int STOP_BIT = 7;
   localparam int RELEASE_MODE_BIT = 6;
   localparam int WARMUP_SEL_LSB = 2;
   // system_control_two fields
   localparam int XEN_BIT = 7;
   localparam int SYSCK_BIT = 5;
   localparam int IDLE_BIT = 4;
   localparam logic [7:0] SYSCTL1_RST = 8'h00;
   localparam logic [7:0] SYSCTL2_RST = 8'h80;
   // warm-up codes
   localparam logic [1:0] WARMUP_CODE_LONG = 2'h0;
   localparam logic [1:0] WARMUP_CODE_MID = 2'h1;
   localparam logic [1:0] WARMUP_CODE_SHORT = 2'h2;
   // warm-up lengths in fc cycles, divider select 0
   localparam int WARM_LONG_CYC = 3 * 65536;
   localparam int WARM_MID_CYC = 65536;
   localparam int WARM_SHORT_CYC = 16384;
   // power-on warm-up time and reset pin minimum, in ns, at 100 ns clock
   localparam int CLK_PERIOD_NS = 100;
   localparam int POWUP_TIME_NS = 409600;
   localparam int POWUP_CYC = POWUP_TIME_NS / CLK_PERIOD_NS;
   localparam int RSTPIN_TIME_NS = 1200;
   localparam int RSTPIN_CYC = (RSTPIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int NUM_IRQ = 8;
   localparam int WDT_IRQ = 0;
   // operating modes of the sequencer
   typedef enum logic [2:0] {
      MODE_NORMAL = 3'h0,
      MODE_STOP = 3'h1,
      MODE_WARMUP = 3'h2,
      MODE_IDLE = 3'h3,
      MODE_RESET = 3'h4
   } sbrc_mode_t;
endpackage : sbrc_pkg

// File: logic/sbrc_reset_gen.sv
// reset source collection and power-on warm-up stage
`timescale 1ns/10ps
module sbrc_reset_gen (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // sources, all synchronous to ref_clk
   input wire logic pin_rst,
   input wire logic trap_rst,
   input wire logic wdt_rst,
   input wire logic clk_rst,
   input wire logic volt_rst,
   input wire logic trim_rst,
   // combined reset
   output logic dev_rst
);
   typedef struct packed {
      logic [12:0] pcnt;
      logic hold;
   } sbrc_rst_t;
   sbrc_rst_t st;
   sbrc_rst_t next_st;

   ////////////////////////////////////////////////////////////////////
   // power-on and trim hold until power-on warm-up elapsed
   always_comb begin
      next_st = st;
      if (trim_rst) begin
         next_st.hold = 1'b1;
         next_st.pcnt = 13'(sbrc_pkg::POWUP_CYC);
      end else if (st.hold) begin
         if (st.pcnt <= 13'h0001) next_st.hold = 1'b0;
         next_st.pcnt = st.pcnt - 13'h0001;
      end
   end

   // rst is the power-on source and starts the hold stage
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '{pcnt: 13'(sbrc_pkg::POWUP_CYC), hold: 1'b1};
      end else begin
         st <= next_st;
      end
   end

   // seven sources merged; internal ones are plain inputs, not cleared here
   // trim source asserts at once; the hold stage then keeps it for the warm-up time
   assign dev_rst = st.hold | pin_rst | trap_rst | wdt_rst | clk_rst | volt_rst | trim_rst;

   chk_powup_hold: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(trim_rst) |=> dev_rst [*8]) else $error("power-on hold too short");
endmodule : sbrc_reset_gen

// File: logic/sbrc_top.sv
// standby and reset sequencer with register port
`timescale 1ns/10ps
module sbrc_top (
   // clock and power-on reset
   input wire logic ref_clk,
   input wire logic rst,
   // device pins
   input wire logic wake_pin,
   input wire logic reset_pin_n,
   // other internal reset sources
   input wire logic trap_rst,
   input wire logic wdt_rst,
   input wire logic volt_rst,
   input wire logic trim_rst,
   // interrupt requests from peripherals, one-cycle pulses
   input wire logic [7:0] irq_req,
   // software register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // core control
   output logic dev_rst,
   output logic osc_en,
   output logic cpu_run,
   output logic wdt_run,
   output logic periph_run,
   output logic tg_clear,
   output logic vector_take,
   output logic [2:0] vector_num,
   output logic fetch_reset_vector,
   // core flags
   output logic master_irq_enable,
   output logic [1:0] register_bank_select,
   output logic jump_status_flag,
   output logic irq_nesting_flag
);
   typedef struct packed {
      sbrc_pkg::sbrc_mode_t mode;
      logic [7:0] ctl1;
      logic [7:0] ctl2;
      logic [7:0] source_irq_enable;
      logic [7:0] irq_request_latch;
      logic mie;
      logic [1:0] bank;
      logic jump;
      logic nest;
      logic wake_q;
      logic [1:0] rpin_sync;
      logic [1:0] wake_sync;
      logic [7:0] rdata;
      logic vtake;
      logic [2:0] vnum;
      logic fetch;
   } sbrc_st_t;

   sbrc_st_t st;
   sbrc_st_t next_st;
   logic clk_rst;
   logic wake_rise;
   logic wake_hi;
   logic pin_rst;
   logic [7:0] pend;
   logic [2:0] first_src;
   sbrc_warm_if wi ();

   ////////////////////////////////////////////////////////////////////
   // wake pin passed through two flops before use
   assign wake_hi = st.wake_sync[1];
   assign wake_rise = st.wake_sync[1] & ~st.wake_q;
   assign pin_rst = ~st.rpin_sync[1];
   // off or reserved system clock settings force a clock reset
   assign clk_rst = ~st.ctl2[sbrc_pkg::XEN_BIT] | st.ctl2[sbrc_pkg::SYSCK_BIT];
   // pending enabled sources for idle wake
   assign pend = st.irq_request_latch & st.source_irq_enable;

   // lowest index pending wins the vector
   always_comb begin
      first_src = 3'h0;
      for (int i = sbrc_pkg::NUM_IRQ - 1; i >= 0; i--) begin
         if (pend[i]) first_src = 3'(i);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // warm-up counter control
   assign wi.start = (st.mode != sbrc_pkg::MODE_WARMUP) && (next_st.mode == sbrc_pkg::MODE_WARMUP);
   assign wi.code = st.ctl1[sbrc_pkg::WARMUP_SEL_LSB +: 2];
   assign wi.dbl = 1'b0; // divider select fixed to 0 in this part
   sbrc_warmup u_warm (
      .ref_clk(ref_clk),
      .rst(rst),
      .wi(wi)
   );

   sbrc_reset_gen u_rst (
      .ref_clk(ref_clk),
      .rst(rst),
      .pin_rst(pin_rst),
      .trap_rst(trap_rst),
      .wdt_rst(wdt_rst),
      .clk_rst(clk_rst),
      .volt_rst(volt_rst),
      .trim_rst(trim_rst),
      .dev_rst(dev_rst)
   );

   ////////////////////////////////////////////////////////////////////
   // sequencer, register writes and interrupt latches
   always_comb begin
      next_st = st;
      next_st.wake_sync = {st.wake_sync[0], wake_pin};
      next_st.rpin_sync = {st.rpin_sync[0], reset_pin_n};
      next_st.wake_q = st.wake_sync[1];
      next_st.vtake = 1'b0;
      next_st.fetch = 1'b0;
      next_st.rdata = 8'h00;
      // register writes
      if (reg_wr) begin
         case (reg_addr)
            sbrc_pkg::ADDR_SYSCTL1: next_st.ctl1 = reg_wdata;
            sbrc_pkg::ADDR_SYSCTL2: next_st.ctl2 = reg_wdata & 8'hb0;
            sbrc_pkg::ADDR_IRQ_EN: begin
               next_st.source_irq_enable = reg_wdata;
               next_st.mie = 1'b0;
            end
            // software clears a latch with a load
            sbrc_pkg::ADDR_IRQ_LATCH: next_st.irq_request_latch = reg_wdata;
            sbrc_pkg::ADDR_STATUS: next_st.mie = reg_wdata[0];
            default: ;
         endcase
      end
      // new requests win over a software clear
      next_st.irq_request_latch = next_st.irq_request_latch | irq_req;
      // register reads
      if (reg_rd) begin
         case (reg_addr)
            sbrc_pkg::ADDR_SYSCTL1: next_st.rdata = {st.ctl1[7:2], 2'h0};
            sbrc_pkg::ADDR_SYSCTL2: next_st.rdata = {st.ctl2[7:4], 4'h0};
            sbrc_pkg::ADDR_IRQ_EN: next_st.rdata = st.source_irq_enable;
            sbrc_pkg::ADDR_IRQ_LATCH: next_st.rdata = st.irq_request_latch;
            sbrc_pkg::ADDR_STATUS: next_st.rdata = {st.jump, st.nest, st.bank, 1'b0, st.mode};
            default: next_st.rdata = 8'h00;
         endcase
      end
      case (st.mode)
         sbrc_pkg::MODE_NORMAL: begin
            if (st.ctl1[sbrc_pkg::STOP_BIT]) begin
               // level mode with pin high goes straight to warm-up
               if (st.ctl1[sbrc_pkg::RELEASE_MODE_BIT] && wake_hi) begin
                  next_st.mode = sbrc_pkg::MODE_WARMUP;
               end else begin
                  // edge mode enters regardless of pin level
                  next_st.mode = sbrc_pkg::MODE_STOP;
               end
            end else if (st.ctl2[sbrc_pkg::IDLE_BIT]) begin
               // pending watchdog interrupt is served, idle skipped
               if (st.irq_request_latch[sbrc_pkg::WDT_IRQ]) begin
                  next_st.ctl2[sbrc_pkg::IDLE_BIT] = 1'b0;
                  next_st.vtake = 1'b1;
                  next_st.vnum = 3'(sbrc_pkg::WDT_IRQ);
               end else begin
                  next_st.mode = sbrc_pkg::MODE_IDLE;
               end
            end
         end
         sbrc_pkg::MODE_STOP: begin
            // rising edge releases; also the only way out after a mode switch
            if (wake_rise) begin
               next_st.mode = sbrc_pkg::MODE_WARMUP;
            end
         end
         sbrc_pkg::MODE_WARMUP: begin
            // pin level ignored until warm-up done
            if (wi.done) begin
               next_st.ctl1[sbrc_pkg::STOP_BIT] = 1'b0;
               next_st.mode = sbrc_pkg::MODE_NORMAL;
            end
         end
         sbrc_pkg::MODE_IDLE: begin
            if (|pend) begin
               next_st.ctl2[sbrc_pkg::IDLE_BIT] = 1'b0;
               next_st.mode = sbrc_pkg::MODE_NORMAL;
               // vector when master enable set; otherwise plain resume
               if (st.mie) begin
                  next_st.vtake = 1'b1;
                  next_st.vnum = first_src;
                  next_st.mie = 1'b0;
                  next_st.nest = 1'b1;
               end
            end
         end
         sbrc_pkg::MODE_RESET: begin
            next_st.mode = sbrc_pkg::MODE_NORMAL;
            next_st.fetch = 1'b1;
         end
         default: next_st.mode = sbrc_pkg::MODE_NORMAL;
      endcase
      // device reset from any mode clears control state
      if (dev_rst) begin
         next_st.mode = sbrc_pkg::MODE_RESET;
         next_st.ctl1 = sbrc_pkg::SYSCTL1_RST;
         next_st.ctl2 = sbrc_pkg::SYSCTL2_RST;
         next_st.mie = 1'b0;
         next_st.irq_request_latch = 8'h00;
         next_st.nest = 1'b0;
         next_st.bank = 2'h0;
         next_st.jump = 1'b1;
      end
   end

   // state register; reset pin sync comes up released
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '{mode: sbrc_pkg::MODE_RESET, ctl1: sbrc_pkg::SYSCTL1_RST,
                 ctl2: sbrc_pkg::SYSCTL2_RST, jump: 1'b1, rpin_sync: 2'h3, default: '0};
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // clock gating per mode; frozen core keeps its state
   assign osc_en = st.mode != sbrc_pkg::MODE_STOP;
   assign cpu_run = st.mode == sbrc_pkg::MODE_NORMAL;
   assign wdt_run = st.mode == sbrc_pkg::MODE_NORMAL;
   assign periph_run = (st.mode == sbrc_pkg::MODE_NORMAL) || (st.mode == sbrc_pkg::MODE_IDLE);
   // timing generator restarts from zero after stop and reset
   assign tg_clear = (st.mode == sbrc_pkg::MODE_STOP) || (st.mode == sbrc_pkg::MODE_WARMUP)
                     || (st.mode == sbrc_pkg::MODE_RESET);
   assign reg_rdata = st.rdata;
   assign vector_take = st.vtake;
   assign vector_num = st.vnum;
   assign fetch_reset_vector = st.fetch;
   assign master_irq_enable = st.mie;
   assign register_bank_select = st.bank;
   assign jump_status_flag = st.jump;
   assign irq_nesting_flag = st.nest;

   ////////////////////////////////////////////////////////////////////
   // checks
   sequence s_edge_stop;
      st.mode == sbrc_pkg::MODE_STOP && !st.ctl1[sbrc_pkg::RELEASE_MODE_BIT];
   endsequence
   // warm-up never falls back to stop
   chk_warm_no_stop: assert property (@(posedge ref_clk) disable iff (rst || dev_rst)
      st.mode == sbrc_pkg::MODE_WARMUP |=> st.mode != sbrc_pkg::MODE_STOP)
      else $error("stop re-entered during warm-up");
   chk_edge_release: assert property (@(posedge ref_clk) disable iff (rst || dev_rst)
      s_edge_stop ##0 wake_rise |=> st.mode == sbrc_pkg::MODE_WARMUP)
      else $error("edge did not release stop");
   chk_stop_holds: assert property (@(posedge ref_clk) disable iff (rst || dev_rst)
      st.mode == sbrc_pkg::MODE_STOP && !wake_rise |=> st.mode == sbrc_pkg::MODE_STOP)
      else $error("stop left without edge");
   // level mode with pin high skips stop
   chk_level_skip: assert property (@(posedge ref_clk) disable iff (rst || dev_rst)
      st.mode == sbrc_pkg::MODE_NORMAL && st.ctl1[sbrc_pkg::STOP_BIT]
      && st.ctl1[sbrc_pkg::RELEASE_MODE_BIT] && wake_hi
      |=> st.mode == sbrc_pkg::MODE_WARMUP) else $error("level skip missed");
   // request bit cleared on leaving warm-up
   chk_stop_clear: assert property (@(posedge ref_clk) disable iff (rst || dev_rst)
      st.mode == sbrc_pkg::MODE_WARMUP ##1 st.mode == sbrc_pkg::MODE_NORMAL
      |-> !st.ctl1[sbrc_pkg::STOP_BIT]) else $error("stop bit not cleared");
   // idle gates cpu and watchdog only
   chk_idle_gate: assert property (@(posedge ref_clk) disable iff (rst)
      st.mode == sbrc_pkg::MODE_IDLE |-> !cpu_run && !wdt_run && periph_run)
      else $error("idle gating wrong");
   chk_idle_vector: assert property (@(posedge ref_clk) disable iff (rst || dev_rst)
      st.mode == sbrc_pkg::MODE_IDLE && |pend && st.mie |=> vector_take && cpu_run)
      else $error("idle wake did not vector");
   chk_pin_reset: assert property (@(posedge ref_clk) disable iff (rst)
      pin_rst |=> st.mode == sbrc_pkg::MODE_RESET && jump_status_flag)
      else $error("reset pin ignored");
endmodule : sbrc_top

// File: logic/sbrc_warm_if.sv
// carrier between sequencer and warm-up counter
`timescale 1ns/10ps
interface sbrc_warm_if;
   logic start;
   logic [1:0] code;
   logic dbl;
   logic done;
   modport seq (output start, output code, output dbl, input done);
   modport cnt (input start, input code, input dbl, output done);
endinterface : sbrc_warm_if

// File: logic/sbrc_warmup.sv
// oscillator warm-up counter
`timescale 1ns/10ps
module sbrc_warmup (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // request and completion
   sbrc_warm_if.cnt wi
);
   typedef struct packed {
      logic run;
      logic [18:0] cnt;
      logic done;
   } sbrc_wst_t;
   sbrc_wst_t st;
   sbrc_wst_t next_st;
   logic [18:0] len;

   ////////////////////////////////////////////////////////////////////
   // length per code
   always_comb begin
      case (wi.code)
         sbrc_pkg::WARMUP_CODE_LONG: len = 19'(sbrc_pkg::WARM_LONG_CYC);
         sbrc_pkg::WARMUP_CODE_MID: len = 19'(sbrc_pkg::WARM_MID_CYC);
         default: len = 19'(sbrc_pkg::WARM_SHORT_CYC); // reserved code taken as short
      endcase
   end

   // count, doubled when divider select is set
   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      if (wi.start) begin
         next_st.run = 1'b1;
         next_st.cnt = wi.dbl ? {len[17:0], 1'b0} : len;
      end else if (st.run) begin
         if (st.cnt <= 19'h00001) begin
            next_st.run = 1'b0;
            next_st.done = 1'b1;
         end
         next_st.cnt = st.cnt - 19'h00001;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign wi.done = st.done;
endmodule : sbrc_warmup

// File: tb/sbrc_pin_model.sv
// wake pin source and reset pin circuitry outside the sequencer
`timescale 1ns/10ps
module sbrc_pin_model (
   // clock
   input wire logic ref_clk,
   // commands from the bench
   input wire logic wake_lvl,
   input wire logic rst_req,
   // device pins
   output logic wake_pin,
   output logic reset_pin_n
);
   int low_cnt = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // the wake source is a driven square wave in use, so it never floats
   assign wake_pin = wake_lvl;
   // minimum low time
   // one cycle over the minimum so the design never sees a marginal pulse
   always @(posedge ref_clk) begin
      if (rst_req) begin
         low_cnt <= sbrc_pkg::RSTPIN_CYC + 1;
      end else if (low_cnt > 0) begin
         low_cnt <= low_cnt - 1;
      end
   end
   // pin has a pull-up: released means high
   assign reset_pin_n = (low_cnt == 0);
endmodule : sbrc_pin_model

// File: tb/sbrc_top_test.sv
// self-checking bench of the standby and reset sequencer
`timescale 1ns/10ps
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
   $display("[FAIL] %0t %s", $time, m); end end
module sbrc_top_test;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic wake_lvl = 1'b0;
   logic rst_req = 1'b0;
   logic wake_pin, reset_pin_n, trap_rst = 1'b0, wdt_rst = 1'b0, volt_rst = 1'b0, trim_rst = 1'b0;
   logic [7:0] irq_req = 8'h00;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic dev_rst, osc_en, cpu_run, wdt_run, periph_run, tg_clear, vector_take, fetch_reset_vector;
   logic [2:0] vector_num, last_vec;
   logic master_irq_enable, jump_status_flag, irq_nesting_flag;
   logic [1:0] register_bank_select;
   int mismatches = 0, cmp_count = 0, n = 0, vt_count = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // clock, partner and design
   always #50 ref_clk = ~ref_clk;
   sbrc_pin_model u_sbrc_pin_model (.ref_clk, .wake_lvl, .rst_req, .wake_pin, .reset_pin_n);
   sbrc_top u_sbrc_top (.ref_clk, .rst, .wake_pin, .reset_pin_n, .trap_rst, .wdt_rst, .volt_rst,
      .trim_rst, .irq_req, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dev_rst, .osc_en,
      .cpu_run, .wdt_run, .periph_run, .tg_clear, .vector_take, .vector_num, .fetch_reset_vector,
      .master_irq_enable, .register_bank_select, .jump_status_flag, .irq_nesting_flag);
   // vector pulses are counted so that a missing or extra one shows up later
   always @(posedge ref_clk) begin
      if (vector_take === 1'b1) begin
         vt_count <= vt_count + 1;
         last_vec <= vector_num;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // shared helpers
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata & m, e, "register read")
   endtask : rd_chk
   task automatic set_wake(input logic v);
      @(posedge ref_clk);
      wake_lvl <= v;
   endtask : set_wake
   function automatic logic pick(input int s);
      case (s)
         0: pick = dev_rst;
         1: pick = cpu_run;
         default: pick = osc_en;
      endcase
   endfunction : pick
   // bounded wait; n holds the cycles spent
   task automatic wait_for(input int s, input logic v, input int lim);
      n = 0;
      while (pick(s) !== v && n < lim) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
   endtask : wait_for
   task automatic wait_rst();
      wait_for(0, 1'b0, 6000);
      `CHK(dev_rst, 1'b0, "reset never released")
      tick(1);
      `CHK(fetch_reset_vector, 1'b1, "no vector fetch")
      `CHK({master_irq_enable, register_bank_select, irq_nesting_flag}, 4'h0, "flags")
      `CHK(jump_status_flag, 1'b1, "jump flag")
   endtask : wait_rst
   task automatic pin_reset();
      @(posedge ref_clk);
      rst_req <= 1'b1;
      @(posedge ref_clk);
      rst_req <= 1'b0;
      #1;
      wait_for(0, 1'b1, 10);
      `CHK(n <= 4, 1'b1, "pin reset slow")
      wait_rst();
   endtask : pin_reset
   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic s_power_on();
      tick(4000);
      `CHK(dev_rst, 1'b1, "power-on hold short")
      wait_rst();
      rd_chk(sbrc_pkg::ADDR_STATUS, 8'hff, 8'h80);
      rd_chk(sbrc_pkg::ADDR_SYSCTL2, 8'hff, sbrc_pkg::SYSCTL2_RST);
      rd_chk(sbrc_pkg::ADDR_IRQ_LATCH, 8'hff, 8'h00);
      rd_chk(4'hf, 8'hff, 8'h00);
   endtask : s_power_on
   // edge mode with the pin high, switch to level, then rising edge and warm-up
   task automatic s_edge_stop();
      set_wake(1'b1);
      wr(sbrc_pkg::ADDR_SYSCTL1, 8'h88);
      tick(3);
      `CHK(osc_en, 1'b0, "edge mode entry")
      wr(sbrc_pkg::ADDR_SYSCTL1, 8'hc8);
      tick(10);
      `CHK(osc_en, 1'b0, "left standby on level")
      set_wake(1'b0);
      tick(5);
      set_wake(1'b1);
      tick(0);
      wait_for(2, 1'b1, 10);
      `CHK(n <= 5, 1'b1, "no release on edge")
      `CHK({cpu_run, tg_clear}, 2'b01, "core not idle in warm-up")
      set_wake(1'b0);
      tick(0);
      wait_for(1, 1'b1, 20000);
      `CHK(n >= sbrc_pkg::WARM_SHORT_CYC - 4, 1'b1, "warm-up short")
      `CHK(n <= sbrc_pkg::WARM_SHORT_CYC + 4, 1'b1, "warm-up long")
      tick(5);
      `CHK({osc_en, cpu_run, tg_clear}, 3'b110, "standby re-entered")
      rd_chk(sbrc_pkg::ADDR_SYSCTL1, 8'h83, 8'h00);
      // plain edge mode: a rising edge from low releases standby
      wr(sbrc_pkg::ADDR_SYSCTL1, 8'h88);
      tick(3);
      `CHK(osc_en, 1'b0, "edge mode stop")
      set_wake(1'b1);
      tick(0);
      wait_for(2, 1'b1, 10);
      `CHK(n <= 5, 1'b1, "edge mode release")
      wait_for(1, 1'b1, 20000);
      `CHK(cpu_run, 1'b1, "edge exit stalled")
   endtask : s_edge_stop
   // level mode with the pin high skips standby; code 01 outlasts code 10
   task automatic s_level_mid();
      set_wake(1'b1);
      wr(sbrc_pkg::ADDR_SYSCTL1, 8'hc4);
      tick(3);
      `CHK(osc_en, 1'b1, "oscillator stopped")
      rd_chk(sbrc_pkg::ADDR_STATUS, 8'h07, 8'h02);
      tick(16400);
      `CHK(cpu_run, 1'b0, "mid warm-up too short")
      pin_reset();
      set_wake(1'b0);
      rd_chk(sbrc_pkg::ADDR_SYSCTL1, 8'hff, sbrc_pkg::SYSCTL1_RST);
   endtask : s_level_mid
   task automatic s_idle();
      wr(sbrc_pkg::ADDR_IRQ_EN, 8'h02);
      wr(sbrc_pkg::ADDR_SYSCTL2, 8'h90);
      tick(2);
      `CHK({cpu_run, wdt_run, periph_run}, 3'b001, "idle gating")
      @(posedge ref_clk);
      irq_req <= 8'h02;
      @(posedge ref_clk);
      irq_req <= 8'h00;
      tick(3);
      `CHK({cpu_run, vt_count}, {1'b1, 32'd0}, "plain wake")
      rd_chk(sbrc_pkg::ADDR_IRQ_LATCH, 8'h02, 8'h02);
      wr(sbrc_pkg::ADDR_IRQ_LATCH, 8'h00);
      rd_chk(sbrc_pkg::ADDR_IRQ_LATCH, 8'hff, 8'h00);
      wr(sbrc_pkg::ADDR_STATUS, 8'h01);
      wr(sbrc_pkg::ADDR_SYSCTL2, 8'h90);
      tick(2);
      @(posedge ref_clk);
      irq_req <= 8'h02;
      @(posedge ref_clk);
      irq_req <= 8'h00;
      tick(3);
      `CHK({cpu_run, vt_count, last_vec}, {1'b1, 32'd1, 3'h1}, "vectored wake")
      wr(sbrc_pkg::ADDR_IRQ_LATCH, 8'h00);
      @(posedge ref_clk);
      irq_req <= 8'h01;
      @(posedge ref_clk);
      irq_req <= 8'h00;
      wr(sbrc_pkg::ADDR_SYSCTL2, 8'h90);
      tick(3);
      `CHK({cpu_run, vt_count, last_vec}, {1'b1, 32'd2, 3'h0}, "idle despite wdt")
   endtask : s_idle
   task automatic s_sources();
      for (int k = 0; k < 4; k++) begin
         @(posedge ref_clk);
         {trap_rst, wdt_rst, volt_rst, trim_rst} <= 4'h8 >> k;
         #1;
         `CHK(dev_rst, 1'b1, "source ignored")
         @(posedge ref_clk);
         {trap_rst, wdt_rst, volt_rst, trim_rst} <= 4'h0;
         #1;
         if (k == 3) begin
            tick(4000);
            `CHK(dev_rst, 1'b1, "trim hold short")
         end
         wait_rst();
      end
      wr(sbrc_pkg::ADDR_SYSCTL2, 8'h00);
      tick(0);
      `CHK(dev_rst, 1'b1, "clock reset missing")
      wait_rst();
      wr(sbrc_pkg::ADDR_SYSCTL2, 8'h90);
      tick(2);
      pin_reset();
      tick(2);
      `CHK(cpu_run, 1'b1, "not normal after reset")
   endtask : s_sources
   ////////////////////////////////////////////////////////////////////////////////
   // verdict and run control
   task automatic summarize();
      $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize
   // a clean run takes about 58000 cycles; 90000 means a hang
   initial begin
      #9000000;
      mismatches++;
      summarize();
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      s_power_on();
      s_edge_stop();
      s_level_mid();
      s_idle();
      s_sources();
      summarize();
   end
endmodule : sbrc_top_test
